/* File: core/obuf_pkg.sv */
// Constants shared by the output sample buffer sequencer
package obuf_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_BOARD_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFF_BUF_OPS = 8'h3C;
  localparam logic [7:0] OFF_FILL_LEVEL = 8'h44;
  localparam logic [7:0] OFF_SAMPLE_DATA = 8'h48;
  localparam logic [7:0] OFF_RATE_A = 8'h4C;
  localparam logic [7:0] OFF_RATE_B = 8'h50;
  localparam logic [7:0] OFF_OUT_CONFIG = 8'h54;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h58;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h5C;

  // ************************************************************
  // Board control fields
  // ************************************************************
  localparam int BC_JOINT_UPDATE = 18;
  localparam int BC_SW_CLOCK = 20;
  localparam int BC_RATE_A_EN = 21;
  localparam int BC_RATE_B_EN = 22;
  localparam int BC_SW_TRIGGER = 23;
  localparam logic [31:0] BOARD_CTRL_RESET = 32'h2208_0000;

  // ************************************************************
  // Buffer operations fields
  // ************************************************************
  localparam int BO_LOOP = 0;
  localparam int BO_CLOCK_EN = 1;
  localparam int BO_BURST = 2;
  localparam int BO_CLEAR = 3;
  localparam int BO_RELOAD_REQ = 4;
  localparam int BO_RELOAD_GRANT = 5;
  localparam int BO_EXT_CLOCK = 6;
  localparam int BO_EXT_TRIGGER = 7;
  localparam int BO_EMPTY = 8;
  localparam int BO_FULL = 9;
  localparam int BO_IN_BURST = 10;

  // ************************************************************
  // Sample word, rates, channels, interrupts
  // ************************************************************
  localparam int SAMPLE_W = 20;
  localparam int TAG_BIT = 24;
  localparam int RATE_W = 24;
  localparam logic [23:0] RATE_A_RESET = 24'h00_0200;
  localparam logic [23:0] RATE_B_RESET = 24'h00_3000;
  localparam int NUM_CHAN = 16;
  localparam logic [4:0] CHAN_COUNT_RESET = 5'h10;
  localparam int IRQ_W = 4;
  localparam int IRQ_GRANTED = 0;
  localparam int IRQ_CLOSED = 1;
  localparam int IRQ_BURST_DONE = 2;
  localparam int IRQ_EMPTY = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/output_sample_buffer_sequencer.sv */
// Sample FIFO, loop/reload sequencing, bursts and register slave
// ************************************************************
// ************************************************************
module output_sample_buffer_sequencer
  import obuf_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output logic s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_clock_in,
  input wire ext_trigger_in,
  output logic sync_clock_out,
  output logic sync_trigger_out,
  output logic [SAMPLE_W-1:0] dac_data,
  output logic [3:0] dac_chan,
  output logic dac_write,
  output logic dac_update,
  output logic irq
);
  localparam int DEPTH = 1 << ADDR_W;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    case (a)
      OFF_BOARD_CTRL, OFF_IRQ_STATUS, OFF_BUF_OPS, OFF_FILL_LEVEL, OFF_SAMPLE_DATA,
      OFF_RATE_A, OFF_RATE_B, OFF_OUT_CONFIG, OFF_IRQ_ENABLE, OFF_IRQ_CLEAR: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic do_write;
  logic [31:0] board_ctrl;
  logic loop_mode, clock_en, burst_mode, ext_clock_sel, ext_trigger_sel;
  logic clear_req, reload_req, reload_granted;
  logic [RATE_W-1:0] rate_a, rate_b;
  logic [4:0] chan_count;
  logic [IRQ_W-1:0] irq_status, irq_enable, irq_event;
  logic [SAMPLE_W:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr, rd_ptr;
  logic [ADDR_W:0] fill;
  logic empty, full;
  logic [SAMPLE_W:0] head;
  logic head_tag;
  logic host_push, recirc, pop, push;
  logic ext_clock_d, ext_trigger_d;
  logic sample_tick, trigger;
  logic in_burst, group_busy;
  logic [3:0] chan;
  logic group_end;

  rate_if rate_a_if ();
  rate_if rate_b_if ();

  rate_divider gen_a (.clk(clk), .rst(rst), .port(rate_a_if.gen));
  rate_divider gen_b (.clk(clk), .rst(rst), .port(rate_b_if.gen));

  assign rate_a_if.enable = board_ctrl[BC_RATE_A_EN];
  assign rate_a_if.divisor = rate_a;
  assign rate_b_if.enable = board_ctrl[BC_RATE_B_EN];
  assign rate_b_if.divisor = rate_b;

  // ************************************************************
  // Bus write channel
  // ************************************************************
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      board_ctrl <= BOARD_CTRL_RESET;
      rate_a <= RATE_A_RESET;
      rate_b <= RATE_B_RESET;
      chan_count <= CHAN_COUNT_RESET;
      irq_enable <= '0;
    end
    else
    begin
      // Software clock and trigger are one-shot strobes
      board_ctrl[BC_SW_CLOCK] <= 1'b0;
      board_ctrl[BC_SW_TRIGGER] <= 1'b0;
      if (do_write)
      begin
        case (aw_addr)
          OFF_BOARD_CTRL: board_ctrl <= merge(board_ctrl, w_data, w_strb);
          OFF_RATE_A: rate_a <= RATE_W'(merge({8'h00, rate_a}, w_data, w_strb));
          OFF_RATE_B: rate_b <= RATE_W'(merge({8'h00, rate_b}, w_data, w_strb));
          OFF_OUT_CONFIG:
          begin
            if (w_strb[0] && w_data[4:0] != 5'h00 && w_data[4:0] <= 5'(NUM_CHAN))
              chan_count <= w_data[4:0];
          end
          OFF_IRQ_ENABLE:
          begin
            if (w_strb[0])
              irq_enable <= w_data[IRQ_W-1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // Buffer operations and reload handshake
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      loop_mode <= 1'b0;
      clock_en <= 1'b0;
      burst_mode <= 1'b0;
      ext_clock_sel <= 1'b0;
      ext_trigger_sel <= 1'b0;
      clear_req <= 1'b0;
      reload_req <= 1'b0;
      reload_granted <= 1'b0;
    end
    else
    begin
      clear_req <= 1'b0;
      if (do_write && aw_addr == OFF_BUF_OPS && w_strb[0])
      begin
        loop_mode <= w_data[BO_LOOP];
        clock_en <= w_data[BO_CLOCK_EN];
        burst_mode <= w_data[BO_BURST];
        ext_clock_sel <= w_data[BO_EXT_CLOCK];
        ext_trigger_sel <= w_data[BO_EXT_TRIGGER];
        clear_req <= w_data[BO_CLEAR];
        if (w_data[BO_RELOAD_REQ])
          reload_req <= 1'b1;
      end
      if (pop && head_tag && loop_mode)
      begin
        if (reload_granted)
        begin
          // Old set's last sample has left: close again
          reload_granted <= 1'b0;
          reload_req <= 1'b0;
        end
        else if (reload_req)
          reload_granted <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Sample FIFO
  // ************************************************************
  assign empty = (fill == '0);
  assign full = (fill == (ADDR_W+1)'(DEPTH));
  assign head = mem[rd_ptr];
  assign head_tag = head[SAMPLE_W];
  // Blocking the write keeps the looping set intact until the frame boundary
  assign host_push = do_write && aw_addr == OFF_SAMPLE_DATA && !full && !clear_req
                     && !(loop_mode && !reload_granted);
  assign recirc = pop && loop_mode && !reload_granted;
  assign push = host_push || recirc;

  always_ff @(posedge clk)
  begin
    if (recirc)
      mem[wr_ptr] <= head;
    else if (host_push)
      mem[wr_ptr] <= {w_data[TAG_BIT], w_data[SAMPLE_W-1:0]};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else if (clear_req)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        fill <= fill + 1'b1;
      else if (pop && !push)
        fill <= fill - 1'b1;
    end
  end

  // ************************************************************
  // Clock and trigger selection
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_clock_d <= 1'b0;
      ext_trigger_d <= 1'b0;
      sync_clock_out <= 1'b0;
      sync_trigger_out <= 1'b0;
    end
    else
    begin
      ext_clock_d <= ext_clock_in;
      ext_trigger_d <= ext_trigger_in;
      // Initiator mirrors its own clocking for target boards
      sync_clock_out <= sample_tick;
      sync_trigger_out <= trigger;
    end
  end

  assign sample_tick = (clock_en && (ext_clock_sel ? (ext_clock_in && !ext_clock_d)
                        : rate_a_if.tick)) || board_ctrl[BC_SW_CLOCK];
  assign trigger = (ext_trigger_sel ? (ext_trigger_in && !ext_trigger_d)
                    : rate_b_if.tick) || board_ctrl[BC_SW_TRIGGER];

  // ************************************************************
  // Sequencing of channel groups and bursts
  // ************************************************************
  // A group pops one sample per cycle, so a tick must not outrun chan_count cycles
  assign pop = group_busy && !empty;
  assign group_end = pop && (chan == 4'(chan_count - 5'h01) || head_tag);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      group_busy <= 1'b0;
      chan <= '0;
      in_burst <= 1'b0;
    end
    else
    begin
      if (group_busy && (group_end || empty))
        group_busy <= 1'b0;
      else if (sample_tick && !empty && (!burst_mode || in_burst))
        group_busy <= 1'b1;
      if (pop)
        chan <= group_end ? 4'h0 : chan + 1'b1;
      if (burst_mode && in_burst && ((pop && head_tag) || empty))
        in_burst <= 1'b0;
      else if (burst_mode && trigger)
        in_burst <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dac_data <= '0;
      dac_chan <= '0;
      dac_write <= 1'b0;
      dac_update <= 1'b0;
    end
    else
    begin
      dac_write <= pop;
      if (pop)
      begin
        dac_data <= head[SAMPLE_W-1:0];
        dac_chan <= chan;
      end
      dac_update <= board_ctrl[BC_JOINT_UPDATE] ? group_end : pop;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign irq_event[IRQ_GRANTED] = pop && head_tag && loop_mode && reload_req && !reload_granted;
  assign irq_event[IRQ_CLOSED] = pop && head_tag && loop_mode && reload_granted;
  assign irq_event[IRQ_BURST_DONE] = burst_mode && in_burst && ((pop && head_tag) || empty);
  assign irq_event[IRQ_EMPTY] = pop && fill == (ADDR_W+1)'(1) && !push;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      // A new event outranks a clear in the same cycle
      if (do_write && aw_addr == OFF_IRQ_CLEAR && w_strb[0])
        irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      irq <= |(irq_status & irq_enable);
    end
  end

  // ************************************************************
  // Bus read channel
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_BOARD_CTRL: s_axi_rdata <= board_ctrl;
        OFF_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
        OFF_BUF_OPS: s_axi_rdata <= 32'({in_burst, full, empty, ext_trigger_sel,
                                         ext_clock_sel, reload_granted, reload_req, 1'b0,
                                         burst_mode, clock_en, loop_mode});
        OFF_FILL_LEVEL: s_axi_rdata <= 32'(fill);
        OFF_RATE_A: s_axi_rdata <= 32'(rate_a);
        OFF_RATE_B: s_axi_rdata <= 32'(rate_b);
        OFF_OUT_CONFIG: s_axi_rdata <= 32'(chan_count);
        OFF_IRQ_ENABLE: s_axi_rdata <= 32'(irq_enable);
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: core/rate_divider.sv */
// Programmable rate divider producing one-cycle ticks
module rate_divider
  import obuf_pkg::*;
(
  input wire clk,
  input wire rst,
  rate_if.gen port
);
  logic [RATE_W-1:0] count;
  logic tick_q;

  assign port.tick = tick_q;

  // ************************************************************
  // Divider: one tick every divisor+1 cycles
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      tick_q <= 1'b0;
    end
    else if (!port.enable)
    begin
      count <= '0;
      tick_q <= 1'b0;
    end
    else if (count >= port.divisor)
    begin
      count <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick_q <= 1'b0;
    end
  end
endmodule

/* File: core/rate_if.sv */
// Rate generator hookup between the sequencer and its dividers
interface rate_if;
  import obuf_pkg::*;
  logic enable;
  logic [RATE_W-1:0] divisor;
  logic tick;
  modport gen (input enable, input divisor, output tick);
  modport user (output enable, output divisor, input tick);
endinterface

/* File: tb/obuf_props.sv */
// Concurrent checks on the output sample buffer sequencer ports
module obuf_props
  import obuf_pkg::*;
(
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input logic s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_clock_in,
  input wire ext_trigger_in,
  input logic sync_clock_out,
  input logic sync_trigger_out,
  input logic [SAMPLE_W-1:0] dac_data,
  input logic [3:0] dac_chan,
  input logic dac_write,
  input logic dac_update,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire aw_go = s_axi_awvalid && s_axi_awready;
  wire w_go = s_axi_wvalid && s_axi_wready;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************
  // Bus answers
  // ****************
  reset_ready_a:
    assert property ($fell(rst) |-> s_axi_awready && s_axi_arready)
    else $error("bus not ready after reset");
  sample_okay_a:
    assert property (aw_go && w_go && s_axi_awaddr == OFF_SAMPLE_DATA |=> ##1 (s_axi_bvalid
      && s_axi_bresp == RESP_OKAY)) else $error("sample write not answered OKAY");
  write_busy_a:
    assert property (aw_go && w_go |=> ##1 (s_axi_bvalid && !s_axi_awready && !s_axi_wready))
    else $error("write answer late or channels reopened");
  write_release_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not released");
  unmapped_read_a:
    assert property (ar_go && s_axi_araddr == 8'h08 |=> s_axi_rvalid
      && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  read_busy_a:
    assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or address reopened");
  // ****************
  // Sample stream
  // ****************
  update_with_write_a:
    assert property (dac_update |-> dac_write) else $error("update without sample");
  chan_order_a:
    assert property (dac_write ##1 dac_write |-> dac_chan == $past(dac_chan) + 4'h1
      || dac_chan == 4'h0) else $error("channel order broken");
  data_hold_a:
    assert property (!dac_write |-> $stable(dac_data) && $stable(dac_chan))
    else $error("sample changed without write");
  group_c: cover property (dac_write && dac_chan == 4'h3);
  irq_c: cover property ($rose(irq));
  trigger_c: cover property (sync_trigger_out);
endmodule

bind output_sample_buffer_sequencer obuf_props chk_u (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_clock_in(ext_clock_in), .ext_trigger_in(ext_trigger_in),
  .sync_clock_out(sync_clock_out), .sync_trigger_out(sync_trigger_out),
  .dac_data(dac_data), .dac_chan(dac_chan), .dac_write(dac_write),
  .dac_update(dac_update), .irq(irq)
);

/* File: tb/output_sample_buffer_sequencer_tb.sv */
// Self-checking bench for the output sample buffer sequencer
module output_sample_buffer_sequencer_tb
  import obuf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ext_clock_in, ext_trigger_in, ok;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb, dac_chan;
  logic [1:0] bresp, rresp, rr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic sync_clock_out, sync_trigger_out, dac_write, dac_update, irq;
  logic [SAMPLE_W-1:0] dac_data;
  logic [23:0] outq[$];
  int fail_count = 0;
  int n_tests = 0;
  int n_upd = 0;
  int n_trig = 0;
  int n_clk = 0;
  // Small FIFO depth keeps the run short
  output_sample_buffer_sequencer #(.ADDR_W(6)) dut_u (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clock_in(ext_clock_in), .ext_trigger_in(ext_trigger_in),
    .sync_clock_out(sync_clock_out), .sync_trigger_out(sync_trigger_out),
    .dac_data(dac_data), .dac_chan(dac_chan), .dac_write(dac_write),
    .dac_update(dac_update), .irq(irq)
  );
  pci_host_model host_u (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (dac_write) outq.push_back({dac_chan, dac_data});
    if (dac_update) n_upd++;
    if (sync_trigger_out) n_trig++;
    if (sync_clock_out) n_clk++;
  end
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    host_u.rd(a, rv, rr);
    chk($sformatf("register %h", a), exp, rv & m);
  endtask
  task automatic expect_out(input logic [3:0] ch, input logic [19:0] d);
    chk("dac sample", {8'h00, ch, d}, outq.size() > 0 ? 32'(outq.pop_front()) : 32'hFFFF_FFFF);
  endtask
  // Software clock strobe with joint update on; fixed wait covers a short group
  task automatic tick();
    host_u.wr(OFF_BOARD_CTRL, BOARD_CTRL_RESET | 32'h0014_0000);
    repeat (8) @(posedge clk);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole sequence needs a few hundred cycles; this 20000-cycle limit is generous
  initial
  begin
    #200us;
    fail_count++;
    final_report();
  end
  // ****************
  // Tests
  // ****************
  initial
  begin
    rst = 1'b1;
    ext_clock_in = 1'b0;
    ext_trigger_in = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reg_is(OFF_BOARD_CTRL, BOARD_CTRL_RESET, '1);
    reg_is(OFF_RATE_A, 32'(RATE_A_RESET), '1);
    reg_is(OFF_RATE_B, 32'(RATE_B_RESET), '1);
    reg_is(OFF_OUT_CONFIG, 32'(CHAN_COUNT_RESET), 32'h1F);
    reg_is(OFF_BUF_OPS, 32'h100, 32'h7FF);
    host_u.rd(8'h08, rv, rr);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rr));
    // Open buffer, external clock, outputs update one by one
    host_u.wr(OFF_OUT_CONFIG, 32'h4);
    host_u.load(20'hA0000, 4, 1'b1);
    reg_is(OFF_FILL_LEVEL, 32'h4, '1);
    host_u.wr(OFF_BUF_OPS, 32'h42);
    ext_clock_in <= 1'b1;
    @(posedge clk);
    ext_clock_in <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++)
      expect_out(4'(i), 20'hA0000 + 20'(i));
    chk("separate updates", 32'h4, 32'(n_upd));
    reg_is(OFF_FILL_LEVEL, 32'h0, '1);
    // Closed loop, refused writes, then reload of a new function
    host_u.wr(OFF_BUF_OPS, 32'h8);
    host_u.wr(OFF_OUT_CONFIG, 32'h2);
    host_u.load(20'hB0000, 2, 1'b1);
    host_u.wr(OFF_BUF_OPS, 32'h3);
    host_u.load(20'hC0000, 1, 1'b0);
    reg_is(OFF_FILL_LEVEL, 32'h2, '1);
    n_upd = 0;
    tick();
    expect_out(4'h0, 20'hB0000);
    expect_out(4'h1, 20'hB0001);
    chk("joint update", 32'h1, 32'(n_upd));
    reg_is(OFF_FILL_LEVEL, 32'h2, '1);
    host_u.wr(OFF_BUF_OPS, 32'h13);
    reg_is(OFF_BUF_OPS, 32'h10, 32'h30);
    tick();
    host_u.await_grant(ok);
    chk("granted", 32'h1, 32'(ok));
    expect_out(4'h0, 20'hB0000);
    expect_out(4'h1, 20'hB0001);
    host_u.load(20'hD0000, 2, 1'b1);
    tick();
    expect_out(4'h0, 20'hB0000);
    expect_out(4'h1, 20'hB0001);
    reg_is(OFF_FILL_LEVEL, 32'h2, '1);
    reg_is(OFF_BUF_OPS, 32'h1, 32'h31);
    tick();
    expect_out(4'h0, 20'hD0000);
    expect_out(4'h1, 20'hD0001);
    reg_is(OFF_FILL_LEVEL, 32'h2, '1);
    // Interrupt held back by its enable, then raised and cleared
    chk("irq masked", 32'h0, 32'(irq));
    reg_is(OFF_IRQ_STATUS, 32'h3, 32'h3);
    host_u.wr(OFF_IRQ_ENABLE, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    host_u.wr(OFF_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    // Triggered bursts: one tagged, one untagged that runs dry
    host_u.wr(OFF_BUF_OPS, 32'h8);
    host_u.load(20'hE0000, 2, 1'b1);
    host_u.load(20'hE0002, 2, 1'b0);
    host_u.wr(OFF_BUF_OPS, 32'h86);
    tick();
    chk("no burst yet", 32'h0, 32'(outq.size()));
    for (int b = 0; b < 2; b++)
    begin
      ext_trigger_in <= 1'b1;
      @(posedge clk);
      ext_trigger_in <= 1'b0;
      repeat (3) tick();
      chk("burst length", 32'h2, 32'(outq.size()));
      expect_out(4'h0, 20'hE0000 + 20'(2 * b));
      expect_out(4'h1, 20'hE0001 + 20'(2 * b));
    end
    chk("trigger pulses", 32'h2, 32'(n_trig));
    chk("clock mirror", 32'hC, 32'(n_clk));
    reg_is(OFF_BUF_OPS, 32'h100, 32'h100);
    final_report();
  end
endmodule

/* File: tb/pci_host_model.sv */
// Host model: register bus master that fills and steers the sample buffer
module pci_host_model
  import obuf_pkg::*;
(
  input wire clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire wready,
  input wire bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Entered just after a rising edge; each channel drops only once taken
  // Response ready lines stay high between calls, so back to back calls never toggle them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
  endtask
  // Frame-end tag only on the very last sample of the set
  task automatic load(input logic [19:0] base, input int n, input logic tag_last);
    for (int i = 0; i < n; i++)
      wr(OFF_SAMPLE_DATA, {7'h00, tag_last && i == n - 1, 4'h0, base + 20'(i)});
  endtask
  // Polls the reload grant bit for at most 50 reads before new samples go in
  task automatic await_grant(output logic ok);
    logic [31:0] d;
    logic [1:0] r;
    ok = 1'b0;
    for (int i = 0; i < 50 && ok !== 1'b1; i++)
    begin
      rd(OFF_BUF_OPS, d, r);
      ok = d[BO_RELOAD_GRANT];
    end
  endtask
endmodule
